// file: i2cm_seq_regs.svh
// Timing constants and bit positions for the two-wire master sequencer.
`ifndef I2CM_SEQ_REGS_SVH
`define I2CM_SEQ_REGS_SVH
`define CLK_PERIOD_NS  10
`define SCL_HALF_NS    5000
`define SCL_HALF_CYC   ((`SCL_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W          10
`define BIT_W          4
`define ACK_BIT        4'h8
`define FIRST_BIT      4'h0
`define MSB_BIT        7
`define RW_BIT         0
`define BYTE_W         8
`endif

// file: i2cm_pkg.sv
// Types shared by the two-wire master sequencer and its helpers.
package i2cm_pkg;
    typedef enum logic [2:0] {
        ST_IDLE    = 3'h0,
        ST_START   = 3'h1,
        ST_HOLD    = 3'h3,
        ST_XFER    = 3'h2,
        ST_STOP    = 3'h6,
        ST_PARK    = 3'h7,
        ST_RELEASE = 3'h5
    } seq_state_t;

    typedef enum logic [1:0] {
        HK_ADDR = 2'h0,
        HK_DONE = 2'h1,
        HK_RX   = 2'h3,
        HK_TXD  = 2'h2
    } hold_kind_t;

    typedef enum logic [1:0] {
        BK_ADDR1 = 2'h0,
        BK_ADDR2 = 2'h1,
        BK_DATA  = 2'h3
    } byte_kind_t;

    typedef struct packed {
        logic       start_req;
        logic       stop_req;
        logic       ack_en;
        logic       ten_bit;
        logic       rx_role;
        logic       event_irq_enable;
        logic       peripheral_on_bit;
        logic       sr1_read;
        logic       dr_write;
        logic       cr_write;
        logic [7:0] dr_wdata;
    } sw_ctrl_t;

    typedef struct packed {
        logic master_select_flag;
        logic event_pending_flag;
        logic start_sent_flag;
        logic byte_done_flag;
        logic ack_failure_flag;
        logic bus_busy;
        logic event_irq;
    } status_t;
endpackage : i2cm_pkg

// file: line_sync.sv
// Two-flop synchronisers for the bus lines.
`timescale 1ns/1ns
`default_nettype none
module line_sync #(
    parameter int W = 2
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta_reg;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_reg[i] <= 1'b1;
                q[i]        <= 1'b1;
            end else begin
                meta_reg[i] <= d[i];
                q[i]        <= meta_reg[i];
            end
        end
    end
endmodule : line_sync
`default_nettype wire

// file: rx_buf2.sv
// Two-entry receive buffer with valid and ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module rx_buf2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         arst_n,
    input  wire logic         in_valid,
    output var  logic         in_ready,
    input  wire logic [W-1:0] in_data,
    output var  logic         out_valid,
    input  wire logic         out_ready,
    output var  logic [W-1:0] out_data
);
    logic         tail_v_reg;
    logic [W-1:0] tail_reg;
    wire logic    pop  = out_valid & out_ready;
    wire logic    push = in_valid & in_ready;

    assign in_ready = ~tail_v_reg;

    // The head is the output register, so the reader sees a flop directly.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            out_valid  <= 1'b0;
            out_data   <= '0;
            tail_v_reg <= 1'b0;
            tail_reg   <= '0;
        end else if (pop && tail_v_reg) begin
            out_data   <= tail_reg;
            tail_v_reg <= push;
            tail_reg   <= in_data;
        end else if (pop) begin
            out_valid <= push;
            out_data  <= in_data;
        end else if (push && !out_valid) begin
            out_valid <= 1'b1;
            out_data  <= in_data;
        end else if (push) begin
            tail_v_reg <= 1'b1;
            tail_reg   <= in_data;
        end
    end
endmodule : rx_buf2
`default_nettype wire

// file: i2c_master_sequencer.sv
// Master-mode sequencer of a two-wire serial interface that idles as a slave.
//
// Functional notes
// - After reset the interface is a slave; only a start makes it master.
// - Start request with bus idle sets master select and drives a start.
// - After the start, event and start-sent flags set; interrupt if enabled.
// - Clock held low until status read then data write; address shifts out.
// - Seven-bit addressing sends exactly one address byte.
// - Ten-bit write header byte sets event, clock held until status read and data write.
// - Second address byte follows; on completion and acknowledge event is set.
// - After address, clock held until status read and control write; role chosen.
// - Each received byte: acknowledge if enabled, then event and byte-done flags.
// - After each received byte clock held until status read then data read.
// - Stop requested before last read issues stop and clears master select.
// - Stop set then cleared during byte-done releases both lines after the byte.
// - Acknowledge failure alone never holds the clock; data line is released too.
`timescale 1ns/1ns
`default_nettype none
`include "i2cm_seq_regs.svh"
module i2c_master_sequencer
    import i2cm_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire sw_ctrl_t         ctrl,
    input  wire logic             rx_ready,
    input  wire logic             scl_i,
    input  wire logic             sda_i,
    output var  logic             scl_o,
    output var  logic             scl_oe,
    output var  logic             sda_o,
    output var  logic             sda_oe,
    output var  status_t          status,
    output var  logic [`BYTE_W-1:0] rx_data,
    output var  logic             rx_valid
);
    localparam int HALF_LAST_I = `SCL_HALF_CYC - 1;
    localparam logic [`CNT_W-1:0] HALF_LAST = HALF_LAST_I[`CNT_W-1:0];

    seq_state_t         state_reg;
    hold_kind_t         hold_reg;
    byte_kind_t         bkind_reg;
    logic [`CNT_W-1:0]  cnt_reg;
    logic [`BIT_W-1:0]  bit_reg;
    logic [1:0]         step_reg;
    logic               phase_reg;
    logic               tx_reg;
    logic [`BYTE_W-1:0] shift_reg;
    logic               addr_rw_reg;
    logic               sr1_seen_reg;
    logic               push_reg;
    logic               stop_q_reg;
    logic               stop_armed_reg;
    logic               release_pend_reg;
    logic               scl_q_reg;
    logic               sda_q_reg;
    logic [1:0]         lines_s;
    logic               buf_in_ready;

    line_sync #(.W(2)) u_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .d      ({scl_i, sda_i}),
        .q      (lines_s)
    );

    rx_buf2 #(.W(`BYTE_W)) u_rxbuf (
        .clk       (clk),
        .arst_n    (arst_n),
        .in_valid  (push_reg),
        .in_ready  (buf_in_ready),
        .in_data   (shift_reg),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // Decides whether software has completed the access that frees a held clock.
    function automatic logic hold_go(input hold_kind_t k, input sw_ctrl_t c,
                                     input logic seen, input logic pop);
        unique case (k)
            HK_ADDR: hold_go = seen & c.dr_write;
            HK_DONE: hold_go = seen & c.cr_write;
            HK_RX:   hold_go = seen & pop;
            HK_TXD:  hold_go = c.dr_write;
        endcase
    endfunction : hold_go

    wire logic scl_s      = lines_s[1];
    wire logic sda_s      = lines_s[0];
    wire logic half_done  = cnt_reg == HALF_LAST;
    wire logic start_det  = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    wire logic stop_det   = scl_s & scl_q_reg & ~sda_q_reg & sda_s;
    wire logic rx_pop     = rx_valid & rx_ready;
    wire logic at_ack     = bit_reg == `ACK_BIT;
    wire logic go         = hold_go(hold_reg, ctrl, sr1_seen_reg, rx_pop);
    wire logic may_turn   = hold_reg != HK_ADDR && hold_reg != HK_TXD;
    wire logic ack_fail   = tx_reg & sda_s & ctrl.ack_en;
    // A receive byte does not begin while the buffer is full: SCL stays low.
    wire logic rx_stall   = ~tx_reg & (bit_reg == `FIRST_BIT) & ~buf_in_ready;
    wire logic drive_bit  = at_ack ? (~tx_reg & ctrl.ack_en)
                                   : (tx_reg & ~shift_reg[`MSB_BIT]);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
            status.bus_busy <= 1'b0;
        end else begin
            scl_q_reg <= scl_s;
            sda_q_reg <= sda_s;
            if (start_det) begin
                status.bus_busy <= 1'b1;
            end else if (stop_det) begin
                status.bus_busy <= 1'b0;
            end
        end
    end

    // Stop toggled high then low while a byte is done arms a line release.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stop_q_reg     <= 1'b0;
            stop_armed_reg <= 1'b0;
        end else begin
            stop_q_reg <= ctrl.stop_req;
            if (ctrl.stop_req && status.byte_done_flag) begin
                stop_armed_reg <= 1'b1;
            end else if (!status.byte_done_flag || (stop_q_reg && !ctrl.stop_req)) begin
                // The clear only counts while the byte is still done, so a plain stop leaves nothing armed.
                stop_armed_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status.event_irq <= 1'b0;
            scl_o            <= 1'b0;
            sda_o            <= 1'b0;
        end else begin
            status.event_irq <= status.event_pending_flag & ctrl.event_irq_enable;
            scl_o            <= 1'b0;
            sda_o            <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg                 <= ST_IDLE;
            hold_reg                  <= HK_ADDR;
            bkind_reg                 <= BK_ADDR1;
            cnt_reg                   <= '0;
            bit_reg                   <= '0;
            step_reg                  <= '0;
            phase_reg                 <= 1'b0;
            tx_reg                    <= 1'b0;
            shift_reg                 <= '0;
            addr_rw_reg               <= 1'b0;
            sr1_seen_reg              <= 1'b0;
            push_reg                  <= 1'b0;
            release_pend_reg          <= 1'b0;
            scl_oe                    <= 1'b0;
            sda_oe                    <= 1'b0;
            status.master_select_flag <= 1'b0;
            status.event_pending_flag <= 1'b0;
            status.start_sent_flag    <= 1'b0;
            status.byte_done_flag     <= 1'b0;
            status.ack_failure_flag   <= 1'b0;
        end else begin
            cnt_reg  <= cnt_reg + 1'b1;
            push_reg <= 1'b0;
            if (stop_armed_reg && stop_q_reg && !ctrl.stop_req && status.byte_done_flag) begin
                release_pend_reg <= 1'b1;
            end
            unique case (state_reg)
                ST_IDLE: begin
                    scl_oe <= 1'b0;
                    sda_oe <= 1'b0;
                    if (ctrl.start_req && !status.bus_busy && ctrl.peripheral_on_bit) begin
                        status.master_select_flag <= 1'b1;
                        state_reg <= ST_START;
                        step_reg  <= '0;
                        cnt_reg   <= '0;
                    end
                end
                ST_START: begin
                    if (step_reg == 2'h0) begin
                        scl_oe <= 1'b0;
                        sda_oe <= 1'b0;
                        if (!(scl_s && sda_s)) begin
                            cnt_reg <= '0;
                        end else if (half_done) begin
                            sda_oe   <= 1'b1;
                            step_reg <= 2'h1;
                            cnt_reg  <= '0;
                        end
                    end else if (half_done) begin
                        scl_oe                    <= 1'b1;
                        status.event_pending_flag <= 1'b1;
                        status.start_sent_flag    <= 1'b1;
                        hold_reg                  <= HK_ADDR;
                        bkind_reg                 <= BK_ADDR1;
                        state_reg                 <= ST_HOLD;
                        step_reg                  <= '0;
                    end
                end
                ST_HOLD: begin
                    scl_oe <= 1'b1;
                    sda_oe <= 1'b0;
                    if (ctrl.sr1_read && status.event_pending_flag) begin
                        sr1_seen_reg <= 1'b1;
                    end
                    if (go) begin
                        sr1_seen_reg              <= 1'b0;
                        status.event_pending_flag <= 1'b0;
                        status.start_sent_flag    <= 1'b0;
                        status.byte_done_flag     <= 1'b0;
                        bit_reg                   <= '0;
                        phase_reg                 <= 1'b0;
                        cnt_reg                   <= '0;
                        step_reg                  <= '0;
                        if (may_turn && ctrl.start_req) begin
                            state_reg <= ST_START;
                        end else if (may_turn && ctrl.stop_req) begin
                            state_reg <= ST_STOP;
                        end else begin
                            unique case (hold_reg)
                                HK_ADDR, HK_TXD: begin
                                    shift_reg <= ctrl.dr_wdata;
                                    tx_reg    <= 1'b1;
                                    state_reg <= ST_XFER;
                                    if (bkind_reg == BK_ADDR1) begin
                                        addr_rw_reg <= ctrl.dr_wdata[`RW_BIT];
                                    end
                                end
                                HK_DONE: begin
                                    if (ctrl.rx_role) begin
                                        tx_reg    <= 1'b0;
                                        state_reg <= ST_XFER;
                                    end else begin
                                        hold_reg <= HK_TXD;
                                    end
                                end
                                HK_RX: begin
                                    tx_reg    <= 1'b0;
                                    state_reg <= ST_XFER;
                                end
                            endcase
                        end
                    end
                end
                ST_XFER: begin
                    if (!phase_reg) begin
                        if (cnt_reg == '0) begin
                            sda_oe <= drive_bit;
                        end
                        if (rx_stall) begin
                            cnt_reg <= '0;
                        end else if (half_done) begin
                            scl_oe    <= 1'b0;
                            phase_reg <= 1'b1;
                            cnt_reg   <= '0;
                        end
                    end else if (!scl_s) begin
                        // A slave stretching SCL restarts the high half.
                        cnt_reg <= '0;
                    end else if (half_done) begin
                        scl_oe    <= 1'b1;
                        phase_reg <= 1'b0;
                        cnt_reg   <= '0;
                        if (!at_ack) begin
                            shift_reg <= {shift_reg[`MSB_BIT-1:0], sda_s};
                            bit_reg   <= bit_reg + 1'b1;
                        end else begin
                            bit_reg <= '0;
                            sda_oe  <= 1'b0;
                            if (release_pend_reg) begin
                                state_reg <= ST_RELEASE;
                            end else if (ack_fail) begin
                                // Clock is let go here so the flag alone never stretches.
                                status.ack_failure_flag   <= 1'b1;
                                status.event_pending_flag <= 1'b1;
                                scl_oe                    <= 1'b0;
                                state_reg                 <= ST_PARK;
                            end else if (!tx_reg) begin
                                push_reg                  <= 1'b1;
                                status.event_pending_flag <= 1'b1;
                                status.byte_done_flag     <= 1'b1;
                                hold_reg                  <= HK_RX;
                                state_reg                 <= ST_HOLD;
                            end else begin
                                status.event_pending_flag <= 1'b1;
                                state_reg                 <= ST_HOLD;
                                unique case (bkind_reg)
                                    BK_ADDR1: begin
                                        if (ctrl.ten_bit && !addr_rw_reg) begin
                                            bkind_reg <= BK_ADDR2;
                                            hold_reg  <= HK_ADDR;
                                        end else begin
                                            bkind_reg <= BK_DATA;
                                            hold_reg  <= HK_DONE;
                                        end
                                    end
                                    BK_ADDR2: begin
                                        bkind_reg <= BK_DATA;
                                        hold_reg  <= HK_DONE;
                                    end
                                    BK_DATA: begin
                                        status.byte_done_flag <= 1'b1;
                                        hold_reg              <= HK_TXD;
                                    end
                                    default: begin
                                        bkind_reg <= BK_DATA;
                                        hold_reg  <= HK_DONE;
                                    end
                                endcase
                            end
                        end
                    end
                end
                ST_STOP: begin
                    unique case (step_reg)
                        2'h0: begin
                            scl_oe <= 1'b1;
                            sda_oe <= 1'b1;
                            if (half_done) begin
                                scl_oe   <= 1'b0;
                                step_reg <= 2'h1;
                                cnt_reg  <= '0;
                            end
                        end
                        2'h1: begin
                            if (!scl_s) begin
                                cnt_reg <= '0;
                            end else if (half_done) begin
                                sda_oe   <= 1'b0;
                                step_reg <= 2'h2;
                                cnt_reg  <= '0;
                            end
                        end
                        default: begin
                            if (half_done) begin
                                status.master_select_flag <= 1'b0;
                                state_reg                 <= ST_IDLE;
                                step_reg                  <= '0;
                            end
                        end
                    endcase
                end
                ST_PARK: begin
                    scl_oe <= 1'b0;
                    if (ctrl.stop_req || ctrl.start_req) begin
                        status.ack_failure_flag   <= 1'b0;
                        status.event_pending_flag <= 1'b0;
                        state_reg                 <= ctrl.stop_req ? ST_STOP : ST_START;
                        step_reg                  <= '0;
                        cnt_reg                   <= '0;
                    end
                end
                ST_RELEASE: begin
                    scl_oe                    <= 1'b0;
                    sda_oe                    <= 1'b0;
                    release_pend_reg          <= 1'b0;
                    status.byte_done_flag     <= 1'b0;
                    status.event_pending_flag <= 1'b0;
                    status.master_select_flag <= 1'b0;
                    state_reg                 <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule : i2c_master_sequencer
`default_nettype wire

// file: i2cm_seq_props.sv
// Port checks on the two-wire master sequencer.
`timescale 1ns/1ns
`default_nettype none
module i2cm_seq_props
    import i2cm_pkg::*;
(
    input wire logic     clk,
    input wire logic     arst_n,
    input wire sw_ctrl_t ctrl,
    input wire logic     scl_oe,
    input wire logic     sda_oe,
    input wire status_t  status
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic ms, ev, sb, bd, af, busy, irq;
    logic      rd1;
    assign {ms, ev, sb, bd, af, busy, irq} = status;
    // A hold may only end once its status has been read, or a stray write would skip a step; an HK_TXD hold ends on a data write alone.
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) rd1 <= 1'b0;
        else rd1 <= ev && (rd1 || ctrl.sr1_read);
    sequence s_stop;
        $fell(sda_oe) && !scl_oe && !$past(scl_oe);
    endsequence
    chk_start_taken: assert property (ctrl.start_req && ctrl.peripheral_on_bit && !busy && !ms |=> ms)
        else $error("start ignored");
    chk_ms_cause: assert property ($rose(ms) |-> $past(ctrl.start_req))
        else $error("master without start");
    chk_start_flags: assert property ($rose(sb) |-> ev && scl_oe)
        else $error("start flags");
    chk_irq_gate: assert property (irq == $past(ev && ctrl.event_irq_enable))
        else $error("event irq");
    chk_hold_low: assert property (sb || bd |-> scl_oe)
        else $error("hold lost");
    chk_hold_exit: assert property ($fell(ev) && !$past(af) |-> $past(rd1))
        else $error("hold left unread");
    chk_fail_free: assert property (af && !sb && !bd |-> ##[0:1000] !scl_oe)
        else $error("failure holds clock");
    chk_stop_ends: assert property (s_stop |-> ##[499:501] !ms)
        else $error("stop timing");
    chk_idle_free: assert property ($fell(ms) |-> !scl_oe && !sda_oe)
        else $error("lines held");
endmodule : i2cm_seq_props
bind i2c_master_sequencer i2cm_seq_props i_props (.*);
`default_nettype wire

// file: i2c_slave_model.sv
// Behavioural target that answers one address and returns bytes from a table.
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_model (
    input  wire logic       clk,
    input  wire logic       scl,
    input  wire logic       sda,
    output var  logic       sda_oe,
    output var  logic [7:0] got,
    output var  logic [1:0] acks
);
    logic [7:0] tx [4] = '{8'ha5, 8'h3c, 8'hff, 8'hff};
    logic       scl_q = 1'b1, sda_q = 1'b1, act = 1'b0, rd = 1'b0;
    int         cnt, nb;
    wire logic  hit = got[7:1] == 7'h50;
    initial sda_oe = 1'b0;
    // Lines are sampled on the system clock; a released line reads high via the pull-up.
    always @(posedge clk) begin
        scl_q <= scl;
        sda_q <= sda;
        if (scl && scl_q && sda != sda_q) begin
            act <= !sda;
            // The start's own SCL fall must not count as a bit, so the count begins one below zero.
            rd  <= 1'b0;
            cnt <= -1;
            nb  <= 0;
        end else if (act && scl && !scl_q) begin
            if (cnt == 8) acks <= {acks[0], sda};
            else if (!rd) got <= {got[6:0], sda};
        end else if (act && !scl && scl_q) begin
            cnt <= cnt == 8 ? 0 : cnt + 1;
            if (cnt == 8) rd <= rd || got[0] && hit;
            if (cnt == 8) nb <= rd ? nb + 1 : 0;
            if (cnt == 7) sda_oe <= !rd && hit;
            else if (cnt == 8) sda_oe <= (rd ? !acks[0] : got[0] && hit) && !tx[rd ? nb + 1 : 0][7];
            else sda_oe <= rd && !tx[nb][6 - cnt];
        end
    end
endmodule : i2c_slave_model
`default_nettype wire

// file: i2c_master_sequencer_tb.sv
// Bench: a seven-bit read of two bytes, an address nobody answers, then ten-bit addressing.
`timescale 1ns/1ns
`default_nettype none
module i2c_master_sequencer_tb
    import i2cm_pkg::*;
;
    logic       clk = 1'b0, arst_n = 1'b0, rx_ready = 1'b0;
    logic       scl_oe, sda_oe, slv_oe, rx_valid;
    logic [7:0] rx_data, got;
    logic [1:0] acks;
    sw_ctrl_t   ctrl = '0;
    status_t    status;
    wire logic  scl = !scl_oe;
    wire logic  sda = !(sda_oe || slv_oe);
    wire logic [7:0] mon = {status, rx_valid};
    int         n_errors = 0, num_checks = 0, cyc = 0;
    i2c_master_sequencer i_dut (.clk, .arst_n, .ctrl, .rx_ready, .scl_i(scl), .sda_i(sda), .scl_o(), .scl_oe,
        .sda_o(), .sda_oe, .status, .rx_data, .rx_valid);
    i2c_slave_model i_slave (.clk, .scl, .sda, .sda_oe(slv_oe), .got, .acks);
    initial forever #5 clk = !clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_errors++;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, seen);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wait_on(input int idx, input logic val);
        while (mon[idx] !== val) @(negedge clk);
    endtask : wait_on
    // Status read, then the access {data write, control write, data read}.
    task automatic step(input logic [2:0] acc, input logic [7:0] d);
        ctrl.sr1_read = 1'b1;
        @(negedge clk);
        ctrl.sr1_read = 1'b0;
        {ctrl.dr_write, ctrl.cr_write, rx_ready} = acc;
        ctrl.dr_wdata = d;
        @(negedge clk);
        {ctrl.dr_write, ctrl.cr_write, rx_ready} = 3'h0;
        repeat (2) @(negedge clk);
    endtask : step
    task automatic open_addr(input logic [7:0] a);
        ctrl.start_req = 1'b1;
        wait_on(5, 1'b1);
        ctrl.start_req = 1'b0;
        @(negedge clk);
        chk("event_irq", 8'h1, status.event_irq);
        step(3'h4, a);
        wait_on(6, 1'b1);
    endtask : open_addr
    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : print_verdict
    initial begin
        {ctrl.peripheral_on_bit, ctrl.ack_en, ctrl.rx_role, ctrl.event_irq_enable} = 4'hf;
        repeat (5) @(negedge clk);
        arst_n = 1'b1;
        chk("master_select", 8'h0, status.master_select_flag);
        repeat (3) @(negedge clk);
        open_addr(8'ha1);
        chk("address", 8'ha1, got);
        step(3'h2, 8'h0);
        for (int i = 0; i < 2; i++) begin
            wait_on(4, 1'b1);
            wait_on(0, 1'b1);
            chk("rx_data", i ? 8'h3c : 8'ha5, rx_data);
            ctrl.ack_en = 1'b0;
            ctrl.stop_req = i[0];
            step(3'h1, 8'h0);
        end
        wait_on(7, 1'b0);
        chk("acks", 8'h1, acks);
        chk("lines", 8'h0, {scl_oe, sda_oe});
        {ctrl.stop_req, ctrl.ack_en} = 2'h1;
        open_addr(8'h44);
        chk("ack_failure", 8'h1, status.ack_failure_flag);
        ctrl.stop_req = 1'b1;
        wait_on(7, 1'b0);
        chk("lines", 8'h0, {scl_oe, sda_oe});
        {ctrl.stop_req, ctrl.ack_en, ctrl.ten_bit} = 3'h1;
        open_addr(8'hf0);
        step(3'h4, 8'h55);
        wait_on(6, 1'b1);
        chk("second_address", 8'h55, got);
        ctrl.start_req = 1'b1;
        step(3'h2, 8'h0);
        open_addr(8'hf1);
        chk("read_header", 8'hf1, got);
        ctrl.stop_req = 1'b1;
        step(3'h2, 8'h0);
        wait_on(7, 1'b0);
        chk("lines", 8'h0, {scl_oe, sda_oe});
        print_verdict();
    end
endmodule : i2c_master_sequencer_tb
`default_nettype wire
